// ---- fpec_pkg.sv ----
// Behaviour
// - Setting start launches selected operation; hardware clears start on completion.
// - Software can set start but never clear it.
// - Enable bit zero inhibits every program or erase operation.
// - Hardware sets sequence error on improper start.
// - Erase select chooses erase (one) or program (zero) decode.
// - Erase codes: F bulk, D general, C secure, 2 page, 0 config byte.
// - Program codes: 3 word, 1 row, 0 config byte; others do nothing.
// - Unlisted operation codes perform no flash operation.
// - All control bits reset to zero, only by power-on reset.
// - Unimplemented control bits and key upper byte read zero.
// - Key register is write-only, low byte, receives unlock values.
// - Processor stalls while an operation runs.
// - Pages align on 1536 bytes, rows on 192 bytes.
package fpec_pkg;
    localparam logic [3:0] FPEC_OFS_CONTROL = 4'h0;
    localparam logic [3:0] FPEC_OFS_KEY = 4'h4;
    localparam logic [3:0] FPEC_OFS_ADDR = 4'h8;
    localparam int FPEC_BIT_START = 15;
    localparam int FPEC_BIT_ENABLE = 14;
    localparam int FPEC_BIT_ERROR = 13;
    localparam int FPEC_BIT_ERASE = 6;
    localparam logic [15:0] FPEC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] FPEC_CONTROL_WMASK = 16'h404F;
    localparam logic [7:0] FPEC_KEY_FIRST = 8'h55;
    localparam logic [7:0] FPEC_KEY_SECOND = 8'hAA;
    localparam int FPEC_PAGE_BYTES = 1536;
    localparam int FPEC_ROW_BYTES = 192;
    localparam int FPEC_ROW_WORDS = 64;
    localparam int FPEC_ERASE_TIME_US = 20;
    localparam int FPEC_ROW_TIME_US = 2;
    localparam int FPEC_WORD_TIME_US = 1;
    localparam int FPEC_CLK_MHZ = 200;
    localparam int FPEC_ERASE_CYCLES = FPEC_ERASE_TIME_US * FPEC_CLK_MHZ;
    localparam int FPEC_ROW_CYCLES = FPEC_ROW_TIME_US * FPEC_CLK_MHZ;
    localparam int FPEC_WORD_CYCLES = FPEC_WORD_TIME_US * FPEC_CLK_MHZ;
    localparam logic [1:0] FPEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPEC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        FPEC_OP_NONE = 4'h0,
        FPEC_OP_BULK_ERASE = 4'h1,
        FPEC_OP_GEN_ERASE = 4'h2,
        FPEC_OP_SEC_ERASE = 4'h3,
        FPEC_OP_PAGE_ERASE = 4'h4,
        FPEC_OP_CFG_ERASE = 4'h5,
        FPEC_OP_WORD_PROG = 4'h6,
        FPEC_OP_ROW_PROG = 4'h7,
        FPEC_OP_CFG_PROG = 4'h8
    } fpec_op_t;

    typedef struct packed {
        logic start;
        logic enable;
        logic error;
        logic erase;
        logic [3:0] code;
    } fpec_ctrl_t;

    typedef enum logic [2:0] {
        FPEC_IDLE = 3'b001,
        FPEC_BUSY = 3'b010,
        FPEC_DONE = 3'b100
    } fpec_state_t;
endpackage : fpec_pkg

// ---- fpec_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpec_decode
    import fpec_pkg::*;
(
    input wire logic erase,
    input wire logic [3:0] code,
    output fpec_op_t op
);
    always_comb begin
        op = FPEC_OP_NONE;
        if (erase) begin
            case (code)
                4'hF: op = FPEC_OP_BULK_ERASE;
                4'hD: op = FPEC_OP_GEN_ERASE;
                4'hC: op = FPEC_OP_SEC_ERASE;
                4'h2: op = FPEC_OP_PAGE_ERASE;
                4'h0: op = FPEC_OP_CFG_ERASE;
                default: op = FPEC_OP_NONE;
            endcase
        end else begin
            case (code)
                4'h3: op = FPEC_OP_WORD_PROG;
                4'h1: op = FPEC_OP_ROW_PROG;
                4'h0: op = FPEC_OP_CFG_PROG;
                default: op = FPEC_OP_NONE;
            endcase
        end
    end
endmodule : fpec_decode
`default_nettype wire

// ---- fpec_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpec_timer
    import fpec_pkg::*;
#(
    parameter int ERASE_CYCLES = FPEC_ERASE_CYCLES,
    parameter int ROW_CYCLES = FPEC_ROW_CYCLES,
    parameter int WORD_CYCLES = FPEC_WORD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load,
    input wire fpec_op_t op,
    output logic expired
);
    logic [23:0] count;
    logic [23:0] next_count;
    always_comb begin
        next_count = 24'(WORD_CYCLES);
        case (op)
            FPEC_OP_BULK_ERASE, FPEC_OP_GEN_ERASE, FPEC_OP_SEC_ERASE,
            FPEC_OP_PAGE_ERASE, FPEC_OP_CFG_ERASE: next_count = 24'(ERASE_CYCLES);
            FPEC_OP_ROW_PROG: next_count = 24'(ROW_CYCLES);
            default: next_count = 24'(WORD_CYCLES);
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 24'h000000;
        end else if (load) begin
            count <= next_count;
        end else if (count != 24'h000000) begin
            count <= count - 24'h000001;
        end
    end
    assign expired = (count == 24'h000001);
endmodule : fpec_timer
`default_nettype wire

// ---- flash_program_erase_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control
    import fpec_pkg::*;
#(
    parameter int ERASE_CYCLES = FPEC_ERASE_CYCLES,
    parameter int ROW_CYCLES = FPEC_ROW_CYCLES,
    parameter int WORD_CYCLES = FPEC_WORD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpuStall,
    output logic flashStrobe,
    output fpec_op_t flashOp,
    output logic [23:0] flashAddr
);
    fpec_ctrl_t ctrl;
    fpec_state_t state;
    fpec_op_t decodedOp;
    logic [1:0] unlockStage;
    logic awHeld;
    logic wHeld;
    logic [3:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic ctrlWrite;
    logic keyWrite;
    logic addrWrite;
    logic startReq;
    logic startOk;
    logic timerExpired;
    logic [23:0] targetAddr;
    logic [23:0] alignedAddr;

    fpec_decode u_decode (
        .erase(ctrl.erase),
        .code(ctrl.code),
        .op(decodedOp)
    );

    fpec_timer #(
        .ERASE_CYCLES(ERASE_CYCLES),
        .ROW_CYCLES(ROW_CYCLES),
        .WORD_CYCLES(WORD_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(startOk),
        .op(decodedOp),
        .expired(timerExpired)
    );

    // Write address and data captured in either order
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            awHeld <= 1'b0;
            awAddr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    always_comb begin
        s_axi_awready = !awHeld && !s_axi_bvalid;
        s_axi_wready = !wHeld && !s_axi_bvalid;
    end

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign ctrlWrite = doWrite && (awAddr == FPEC_OFS_CONTROL);
    assign keyWrite = doWrite && (awAddr == FPEC_OFS_KEY) && wStrb[0];
    assign addrWrite = doWrite && (awAddr == FPEC_OFS_ADDR);
    assign startReq = ctrlWrite && wStrb[1] && wData[FPEC_BIT_START] && !ctrl.start;
    // Start needs unlock just before, enable set by this same write
    assign startOk = startReq && (unlockStage == 2'h2) &&
                     (wData[FPEC_BIT_ENABLE] || !wStrb[1] ? ctrl.enable || wData[FPEC_BIT_ENABLE] : 1'b0);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= FPEC_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (awAddr == FPEC_OFS_CONTROL || awAddr == FPEC_OFS_KEY || awAddr == FPEC_OFS_ADDR) begin
                s_axi_bresp <= FPEC_RESP_OKAY;
            end else begin
                s_axi_bresp <= FPEC_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Unlock tracker: any other write breaks the sequence
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            unlockStage <= 2'h0;
        end else if (keyWrite) begin
            if (wData[7:0] == FPEC_KEY_FIRST) begin
                unlockStage <= 2'h1;
            end else if (wData[7:0] == FPEC_KEY_SECOND && unlockStage == 2'h1) begin
                unlockStage <= 2'h2;
            end else begin
                unlockStage <= 2'h0;
            end
        end else if (doWrite) begin
            unlockStage <= 2'h0;
        end
    end

    // Control register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= '0;
        end else begin
            if (ctrlWrite && !ctrl.start) begin
                if (wStrb[1]) begin
                    ctrl.enable <= wData[FPEC_BIT_ENABLE];
                    ctrl.error <= wData[FPEC_BIT_ERROR];
                end
                if (wStrb[0]) begin
                    ctrl.erase <= wData[FPEC_BIT_ERASE];
                    ctrl.code <= wData[3:0];
                end
            end
            if (startOk) begin
                ctrl.start <= 1'b1;
                ctrl.error <= 1'b0;
            end else if (startReq) begin
                ctrl.error <= 1'b1;
            end
            if (state == FPEC_BUSY && timerExpired) begin
                ctrl.start <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            targetAddr <= 24'h000000;
        end else if (addrWrite && !ctrl.start) begin
            targetAddr <= wData[23:0];
        end
    end

    // Align to page or row boundary in byte address
    always_comb begin
        alignedAddr = targetAddr;
        if (decodedOp == FPEC_OP_PAGE_ERASE) begin
            alignedAddr = targetAddr - 24'(targetAddr % 24'(FPEC_PAGE_BYTES));
        end else if (decodedOp == FPEC_OP_ROW_PROG) begin
            alignedAddr = targetAddr - 24'(targetAddr % 24'(FPEC_ROW_BYTES));
        end
    end

    // Operation sequencer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= FPEC_IDLE;
        end else begin
            case (state)
                FPEC_IDLE: begin
                    if (startOk) begin
                        state <= FPEC_BUSY;
                    end
                end
                FPEC_BUSY: begin
                    if (timerExpired) begin
                        state <= FPEC_DONE;
                    end
                end
                FPEC_DONE: state <= FPEC_IDLE;
                default: state <= FPEC_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cpuStall <= 1'b0;
            flashStrobe <= 1'b0;
            flashOp <= FPEC_OP_NONE;
            flashAddr <= 24'h000000;
        end else begin
            cpuStall <= startOk || (state == FPEC_BUSY && !timerExpired);
            flashStrobe <= startOk && (decodedOp != FPEC_OP_NONE);
            if (startOk) begin
                flashOp <= decodedOp;
                flashAddr <= alignedAddr;
            end else if (state == FPEC_BUSY && timerExpired) begin
                flashOp <= FPEC_OP_NONE;
            end
        end
    end

    // Read channel
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= FPEC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= FPEC_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
                FPEC_OFS_CONTROL: s_axi_rdata <= {16'h0000, ctrl.start, ctrl.enable, ctrl.error,
                                                  6'h00, ctrl.erase, 2'h0, ctrl.code};
                FPEC_OFS_KEY: s_axi_rdata <= 32'h00000000;
                FPEC_OFS_ADDR: s_axi_rdata <= {8'h00, targetAddr};
                default: s_axi_rresp <= FPEC_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
endmodule : flash_program_erase_control
`default_nettype wire

// ---- fpec_checker_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpec_checker
    import fpec_pkg::*;
#(
    parameter int ERASE_CYCLES = FPEC_ERASE_CYCLES,
    parameter int ROW_CYCLES = FPEC_ROW_CYCLES,
    parameter int WORD_CYCLES = FPEC_WORD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic cpuStall,
    input wire logic flashStrobe,
    input wire fpec_op_t flashOp
);
    int stallCnt;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stallCnt <= 0;
        end else begin
            stallCnt <= cpuStall ? stallCnt + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_arKey;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == FPEC_OFS_KEY;
    endsequence
    sequence s_arCtrl;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == FPEC_OFS_CONTROL;
    endsequence
    property p_strobeStall; flashStrobe |-> cpuStall; endproperty
    property p_strobeReal; flashStrobe |-> flashOp != FPEC_OP_NONE; endproperty
    property p_strobePulse; flashStrobe |=> !flashStrobe; endproperty
    property p_opHeld; cpuStall && !flashStrobe |-> $stable(flashOp); endproperty
    property p_idleNone; !cpuStall |-> flashOp == FPEC_OP_NONE; endproperty
    property p_stallBound; stallCnt <= ERASE_CYCLES + 8; endproperty
    property p_keyReadZero; s_arKey |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000; endproperty
    property p_ctrlUnused;
        s_arCtrl |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:7] == 6'h00
            && s_axi_rdata[5:4] == 2'h0;
    endproperty
    a_strobeStall: assert property (p_strobeStall) else $error("strobe without stall");
    a_strobeReal: assert property (p_strobeReal) else $error("strobe with no operation");
    a_strobePulse: assert property (p_strobePulse) else $error("strobe longer than one cycle");
    a_opHeld: assert property (p_opHeld) else $error("operation changed while running");
    a_idleNone: assert property (p_idleNone) else $error("operation shown while idle");
    a_stallBound: assert property (p_stallBound) else $error("stall never ends");
    a_keyReadZero: assert property (p_keyReadZero) else $error("key read not zero");
    a_ctrlUnused: assert property (p_ctrlUnused) else $error("unused control bits not zero");
endmodule : fpec_checker
bind flash_program_erase_control fpec_checker #(.ERASE_CYCLES(ERASE_CYCLES), .ROW_CYCLES(ROW_CYCLES),
    .WORD_CYCLES(WORD_CYCLES)) checkerInst (.sys_clk(sys_clk), .rstn(rstn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .cpuStall(cpuStall), .flashStrobe(flashStrobe), .flashOp(flashOp));
`default_nettype wire

// ---- fpec_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model
    import fpec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cpuStall,
    input wire logic flashStrobe,
    input wire fpec_op_t flashOp,
    output logic [15:0] strobeCount,
    output fpec_op_t lastOp
);
    // Array takes one launch per strobe, only with the core stalled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strobeCount <= 16'h0000;
            lastOp <= FPEC_OP_NONE;
        end else if (flashStrobe && cpuStall) begin
            strobeCount <= strobeCount + 16'h0001;
            lastOp <= flashOp;
        end
    end
endmodule : fpec_flash_model
`default_nettype wire

// ---- test_flash_program_erase_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_flash_program_erase_control
    import fpec_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cpuStall, flashStrobe;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rdat;
    fpec_op_t flashOp, lastOp;
    logic [15:0] strobeCount;
    logic [23:0] flashAddr;
    logic [3:0] wstrb = 4'hF;
    logic bready = 1'b1, rready = 1'b1;
    int miscompares = 0, nChecks = 0;
    // Rows: erase select, operation code, expected array operation
    logic [11:0] rows [20] = '{12'h1F1, 12'h1E0, 12'h1D2, 12'h1C3, 12'h1B0, 12'h130, 12'h124, 12'h110,
        12'h105, 12'h0F0, 12'h0E0, 12'h0D0, 12'h0C0, 12'h0B0, 12'h036, 12'h020, 12'h017, 12'h008,
        12'h150, 12'h090};
    always #2.5 sys_clk = ~sys_clk;
    flash_program_erase_control #(.ERASE_CYCLES(20), .ROW_CYCLES(10), .WORD_CYCLES(5)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpuStall(cpuStall),
        .flashStrobe(flashStrobe), .flashOp(flashOp), .flashAddr(flashAddr));
    fpec_flash_model flash (.sys_clk(sys_clk), .rstn(rstn), .cpuStall(cpuStall),
        .flashStrobe(flashStrobe), .flashOp(flashOp), .strobeCount(strobeCount), .lastOp(lastOp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdat = rdata;
        rsp = rresp;
    endtask : rd
    task automatic launch(input logic [31:0] ctrl);
        wr(FPEC_OFS_CONTROL, ctrl);
        wr(FPEC_OFS_KEY, {24'h000000, FPEC_KEY_FIRST});
        wr(FPEC_OFS_KEY, {24'h000000, FPEC_KEY_SECOND});
        wr(FPEC_OFS_CONTROL, ctrl | 32'h0000_8000);
        repeat (2) @(posedge sys_clk);
    endtask : launch
    task automatic idle();
        do begin
            rd(FPEC_OFS_CONTROL);
        end while (rdat[15] !== 1'b0);
    endtask : idle
    task automatic summarize();
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin : watchdog
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
    initial begin : mainSeq
        logic [31:0] ctrl;
        logic [15:0] c0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_0000);
        rd(FPEC_OFS_KEY);
        chk(rdat, 32'h0000_0000);
        wr(4'hC, 32'h0000_0001);
        chk(rsp, FPEC_RESP_SLVERR);
        wr(FPEC_OFS_CONTROL, 32'hFFFF_3FBF);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_200F);
        wr(FPEC_OFS_CONTROL, 32'h0000_4001);
        wr(FPEC_OFS_CONTROL, 32'h0000_C001);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_6001);
        wr(FPEC_OFS_CONTROL, 32'h0000_4001);
        wr(FPEC_OFS_KEY, 32'h0000_0055);
        wr(FPEC_OFS_KEY, 32'h0000_0000);
        wr(FPEC_OFS_KEY, 32'h0000_00AA);
        wr(FPEC_OFS_CONTROL, 32'h0000_C001);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_6001);
        launch(32'h0000_0001);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_2001);
        chk(strobeCount, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            ctrl = {16'h0000, 9'h080, rows[i][8], 2'b00, rows[i][7:4]};
            c0 = strobeCount;
            wr(FPEC_OFS_ADDR, 32'h0000_0D00);
            launch(ctrl);
            idle();
            chk(rdat, ctrl);
            chk(32'(strobeCount - c0), {31'h0, rows[i][3:0] != 4'h0});
            if (rows[i][3:0] != 4'h0) chk(lastOp, rows[i][3:0]);
            chk(flashAddr, rows[i][3:0] == 4'h4 ? 24'h000C00 : rows[i][3:0] == 4'h7 ? 24'h000CC0 : 24'h000D00);
        end
        rready <= 1'b0;
        rd(FPEC_OFS_ADDR);
        repeat (2) @(posedge sys_clk);
        chk(rvalid, 1'b1);
        chk(rdata, 32'h0000_0D00);
        rready <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(rvalid, 1'b0);
        bready <= 1'b0;
        wr(FPEC_OFS_KEY, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk(bvalid, 1'b1);
        chk(bresp, FPEC_RESP_OKAY);
        bready <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(bvalid, 1'b0);
        launch(32'h0000_404F);
        wr(FPEC_OFS_CONTROL, 32'h0000_4000);
        rd(FPEC_OFS_CONTROL);
        chk(rdat[15], 1'b1);
        chk(cpuStall, 1'b1);
        idle();
        launch(32'h0000_404F);
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        chk(cpuStall, 1'b0);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_0000);
        wr(FPEC_OFS_CONTROL, 32'h0000_4000);
        wstrb <= 4'h1;
        wr(FPEC_OFS_CONTROL, 32'h0000_0042);
        wstrb <= 4'hF;
        rd(FPEC_OFS_CONTROL);
        chk(rdat, 32'h0000_4042);
        summarize();
    end
endmodule : test_flash_program_erase_control
`default_nettype wire
